// [ffm_pkg.sv]
package ffm_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NPORT      = 8;
  localparam int LRN_AW     = 4;
  localparam int LRN_DEPTH  = 16;
  localparam int IPF_DEPTH  = 32;
  localparam int IPF_AW     = 5;
  localparam int MACF_DEPTH = 4;
  localparam int MACF_AW    = 2;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEC_NS        = 1_000_000_000;
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  localparam logic [19:0] AGE_MIN_S = 20'd300;
  localparam logic [19:0] AGE_MAX_S = 20'd1_000_000;
  localparam logic [19:0] AGE_DEF_S = 20'd300;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    IPF_SRC  = 2'b00,
    IPF_DST  = 2'b01,
    IPF_BOTH = 2'b10
  } ffm_ippos_e;

  typedef enum logic [1:0] {
    DR_NONE   = 2'b00,
    DR_FILTER = 2'b01,
    DR_VLAN   = 2'b10,
    DR_SAME   = 2'b11
  } ffm_drop_e;

endpackage : ffm_pkg

// [ffm_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module ffm_fifo #(
  parameter int W = 16,
  parameter int D = ffm_pkg::FIFO_DEPTH
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import ffm_pkg::*;

  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : ffm_fifo

`default_nettype wire

// [ffm_filter.sv]
`timescale 1ns/1ps
`default_nettype none

module ffm_filter #(
  parameter int NPORT   = ffm_pkg::NPORT,
  parameter int SEC_CYC = ffm_pkg::SEC_CYCLES,
  localparam int PW     = $clog2(NPORT)
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     fr_valid,
  output logic                          fr_ready,
  input  wire logic [PW-1:0]            fr_port,
  input  wire logic [47:0]              fr_src_mac,
  input  wire logic [47:0]              fr_dst_mac,
  input  wire logic                     fr_is_ip,
  input  wire logic [31:0]              fr_src_ip,
  input  wire logic [31:0]              fr_dst_ip,
  input  wire logic [11:0]              fr_vid,
  input  wire logic                     ipf_wr,
  input  wire logic [ffm_pkg::IPF_AW-1:0]  ipf_idx,
  input  wire logic                     ipf_en,
  input  wire logic [31:0]              ipf_addr,
  input  wire ffm_pkg::ffm_ippos_e      ipf_pos,
  input  wire logic                     macf_wr,
  input  wire logic [ffm_pkg::MACF_AW-1:0] macf_idx,
  input  wire logic                     macf_en,
  input  wire logic                     macf_discard,
  input  wire logic [47:0]              macf_mac,
  input  wire logic [PW-1:0]            macf_port,
  input  wire logic [19:0]              age_time_s,
  input  wire logic                     mir_apply,
  input  wire logic                     mir_en,
  input  wire logic [PW-1:0]            mir_tgt,
  input  wire logic [NPORT-1:0]         mir_rx_mask,
  input  wire logic [NPORT-1:0]         mir_tx_mask,
  input  wire logic [NPORT-1:0]         lag_mask,
  output logic                          mir_cfg_err,
  output logic                          mir_active,
  output logic                          dec_valid,
  input  wire logic                     dec_ready,
  output logic                          dec_drop,
  output ffm_pkg::ffm_drop_e            dec_reason,
  output logic [NPORT-1:0]              dec_fwd_mask,
  output logic                          dec_mir,
  output logic [PW-1:0]                 dec_mir_port
);
  import ffm_pkg::*;

  if (NPORT < 2 || NPORT > 32) begin : g_bad_nport
    $error("port count must lie between 2 and 32");
  end
  if (SEC_CYC < 2) begin : g_bad_sec
    $error("second length must be at least 2 cycles");
  end

  localparam int DW = 1 + 2 + NPORT + 1 + PW;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [LRN_AW-1:0] ffm_hash(input logic [47:0] m);
    logic [LRN_AW-1:0] h;
    h = '0;
    for (int i = 0; i < 48 / LRN_AW; i++) begin
      h = h ^ m[i*LRN_AW +: LRN_AW];
    end
    return h;
  endfunction : ffm_hash

  function automatic logic [NPORT-1:0] ffm_onehot(input logic [PW-1:0] p);
    logic [NPORT-1:0] v;
    v = '0;
    v[p] = 1'b1;
    return v;
  endfunction : ffm_onehot

  // ****************************************
  // tables
  // ****************************************
  logic              lrn_vld_q  [LRN_DEPTH];
  logic              lrn_hit_q  [LRN_DEPTH];
  logic [47:0]       lrn_mac_q  [LRN_DEPTH];
  logic [PW-1:0]     lrn_port_q [LRN_DEPTH];
  logic [11:0]       lrn_vid_q  [LRN_DEPTH];
  logic              ipf_en_q   [IPF_DEPTH];
  logic [31:0]       ipf_addr_q [IPF_DEPTH];
  ffm_ippos_e        ipf_pos_q  [IPF_DEPTH];
  logic              mf_en_q    [MACF_DEPTH];
  logic              mf_disc_q  [MACF_DEPTH];
  logic [47:0]       mf_mac_q   [MACF_DEPTH];
  logic [PW-1:0]     mf_port_q  [MACF_DEPTH];

  logic              mir_on_q;
  logic [PW-1:0]     mir_tgt_q;
  logic [NPORT-1:0]  mir_rx_q;
  logic [NPORT-1:0]  mir_tx_q;
  logic              mir_err_q;
  logic [31:0]       sec_cnt_q;
  logic [19:0]       age_cnt_q;

  // ****************************************
  // decision
  // ****************************************
  logic [LRN_AW-1:0] s_idx;
  logic [LRN_AW-1:0] d_idx;
  logic              d_hit;
  logic              ipf_hit;
  logic              mf_drop;
  logic              st_hit;
  logic [PW-1:0]     st_port;
  logic              filt;
  logic              same;
  logic              vlan_bad;
  logic [NPORT-1:0]  fwd_raw;
  logic              w_drop;
  ffm_drop_e         w_reason;
  logic [NPORT-1:0]  w_fwd;
  logic              w_mir;
  logic              push;
  logic              fifo_rdy;
  logic [DW-1:0]     w_word;
  logic [DW-1:0]     q_word;

  assign s_idx = ffm_hash(fr_src_mac);
  assign d_idx = ffm_hash(fr_dst_mac);
  assign d_hit = lrn_vld_q[d_idx] && (lrn_mac_q[d_idx] == fr_dst_mac);

  always_comb begin
    ipf_hit = 1'b0;
    for (int i = 0; i < IPF_DEPTH; i++) begin
      if (ipf_en_q[i] && fr_is_ip) begin
        if (ipf_pos_q[i] != IPF_DST && ipf_addr_q[i] == fr_src_ip) ipf_hit = 1'b1;
        if (ipf_pos_q[i] != IPF_SRC && ipf_addr_q[i] == fr_dst_ip) ipf_hit = 1'b1;
      end
    end
  end

  always_comb begin
    mf_drop = 1'b0;
    st_hit  = 1'b0;
    st_port = '0;
    for (int i = 0; i < MACF_DEPTH; i++) begin
      if (mf_en_q[i] && mf_disc_q[i]) begin
        if (mf_mac_q[i] == fr_src_mac || mf_mac_q[i] == fr_dst_mac) mf_drop = 1'b1;
      end
      if (mf_en_q[i] && !mf_disc_q[i] && mf_mac_q[i] == fr_src_mac) begin
        st_hit  = 1'b1;
        st_port = mf_port_q[i];
      end
    end
  end

  assign filt = ipf_hit || mf_drop;

  always_comb begin
    if (st_hit) fwd_raw = ffm_onehot(st_port);
    else if (d_hit) fwd_raw = ffm_onehot(lrn_port_q[d_idx]);
    else fwd_raw = ~ffm_onehot(fr_port);
  end

  assign same     = (st_hit || d_hit) && fwd_raw[fr_port];
  assign vlan_bad = d_hit && !st_hit && (lrn_vid_q[d_idx] != fr_vid);

  always_comb begin
    w_drop   = 1'b1;
    w_reason = DR_FILTER;
    if (filt) w_reason = DR_FILTER;
    else if (vlan_bad) w_reason = DR_VLAN;
    else if (same) w_reason = DR_SAME;
    else begin
      w_drop   = 1'b0;
      w_reason = DR_NONE;
    end
  end

  // copies ride beside the decision; the forward mask is never touched by them
  assign w_fwd = w_drop ? '0 : fwd_raw;
  assign w_mir = mir_on_q && !filt && (mir_rx_q[fr_port] || |(mir_tx_q & w_fwd));
  assign w_word = {w_drop, w_reason, w_fwd, w_mir, mir_tgt_q};

  // back-pressure from the output queue stalls intake
  assign fr_ready = fifo_rdy;
  assign push     = fr_valid && fifo_rdy;

  ffm_fifo #(
    .W (DW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (fr_valid),
    .in_ready  (fifo_rdy),
    .in_data   (w_word),
    .out_valid (dec_valid),
    .out_ready (dec_ready),
    .out_data  (q_word)
  );

  assign {dec_drop, dec_fwd_mask, dec_mir, dec_mir_port} = {q_word[DW-1], q_word[DW-4:0]};
  assign dec_reason  = ffm_drop_e'(q_word[DW-2:DW-3]);
  assign mir_cfg_err = mir_err_q;
  assign mir_active  = mir_on_q;

  // ****************************************
  // filter tables
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < IPF_DEPTH; i++) begin
        ipf_en_q[i]   <= 1'b0;
        ipf_addr_q[i] <= '0;
        ipf_pos_q[i]  <= IPF_SRC;
      end
    end else if (ipf_wr) begin
      ipf_en_q[ipf_idx]   <= ipf_en;
      ipf_addr_q[ipf_idx] <= ipf_addr;
      ipf_pos_q[ipf_idx]  <= ipf_pos;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < MACF_DEPTH; i++) begin
        mf_en_q[i]   <= 1'b0;
        mf_disc_q[i] <= 1'b0;
        mf_mac_q[i]  <= '0;
        mf_port_q[i] <= '0;
      end
    end else if (macf_wr) begin
      mf_en_q[macf_idx]   <= macf_en;
      mf_disc_q[macf_idx] <= macf_discard;
      mf_mac_q[macf_idx]  <= macf_mac;
      mf_port_q[macf_idx] <= macf_port;
    end
  end

  // ****************************************
  // mirror setup
  // ****************************************
  logic mir_bad;
  assign mir_bad = mir_en && ((mir_rx_mask[mir_tgt] || mir_tx_mask[mir_tgt])
                   || lag_mask[mir_tgt]);

  // a refused setup leaves the previous one running
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mir_on_q  <= 1'b0;
      mir_tgt_q <= '0;
      mir_rx_q  <= '0;
      mir_tx_q  <= '0;
      mir_err_q <= 1'b0;
    end else if (mir_apply) begin
      mir_err_q <= mir_bad;
      if (!mir_bad) begin
        mir_on_q  <= mir_en;
        mir_tgt_q <= mir_tgt;
        mir_rx_q  <= mir_rx_mask;
        mir_tx_q  <= mir_tx_mask;
      end
    end
  end

  // ****************************************
  // learning and aging
  // ****************************************
  logic [19:0] age_lim;
  logic        sec_tick;
  logic        sweep;

  assign age_lim = (age_time_s < AGE_MIN_S) ? AGE_MIN_S :
                   (age_time_s > AGE_MAX_S) ? AGE_MAX_S : age_time_s;
  assign sec_tick = (sec_cnt_q == 32'(SEC_CYC - 1));
  assign sweep    = sec_tick && (age_cnt_q >= age_lim - 20'd1);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sec_cnt_q <= '0;
      age_cnt_q <= '0;
    end else begin
      sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 32'd1;
      if (sweep) age_cnt_q <= '0;
      else if (sec_tick) age_cnt_q <= age_cnt_q + 20'd1;
    end
  end

  // an entry idle for a whole period loses its hit mark, then its slot;
  // static entries live in the MAC filter table and are never swept
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < LRN_DEPTH; i++) begin
        lrn_vld_q[i]  <= 1'b0;
        lrn_hit_q[i]  <= 1'b0;
        lrn_mac_q[i]  <= '0;
        lrn_port_q[i] <= '0;
        lrn_vid_q[i]  <= '0;
      end
    end else begin
      if (sweep) begin
        for (int i = 0; i < LRN_DEPTH; i++) begin
          if (!lrn_hit_q[i]) lrn_vld_q[i] <= 1'b0;
          lrn_hit_q[i] <= 1'b0;
        end
      end
      if (push && d_hit) lrn_hit_q[d_idx] <= 1'b1;
      if (push && !filt) begin
        lrn_vld_q[s_idx]  <= 1'b1;
        lrn_hit_q[s_idx]  <= 1'b1;
        lrn_mac_q[s_idx]  <= fr_src_mac;
        lrn_port_q[s_idx] <= fr_port;
        lrn_vid_q[s_idx]  <= fr_vid;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_same_port: assert property (push && !w_drop |-> !w_fwd[fr_port])
    else $error("frame forwarded back to ingress port");
  a_filter_wins: assert property (push && filt |-> w_drop && w_reason == DR_FILTER
                 && w_fwd == '0 && !w_mir)
    else $error("filter hit did not drop frame");
  a_discard_mac: assert property (push && mf_drop |-> w_drop)
    else $error("discard entry frame not dropped");
  a_static_pin: assert property (push && st_hit && !w_drop
                |-> w_fwd == ffm_onehot(st_port))
    else $error("static entry port not honoured");
  a_vlan_drop: assert property (push && vlan_bad && !filt
               |-> w_drop && w_reason == DR_VLAN)
    else $error("cross vlan frame not dropped");
  a_learn_src: assert property (push && !filt && !sweep |=> lrn_vld_q[$past(s_idx)]
               && lrn_port_q[$past(s_idx)] == $past(fr_port))
    else $error("source address not learned");
  a_age_range: assert property (sweep |-> age_cnt_q >= AGE_MIN_S - 20'd1)
    else $error("aging sweep below the floor");
  a_mir_reject: assert property (mir_apply && mir_bad
                |=> mir_err_q && $stable(mir_tgt_q) && $stable(mir_on_q))
    else $error("bad mirror setup accepted");
  a_mir_lag: assert property (mir_apply && mir_en && lag_mask[mir_tgt]
             |=> mir_err_q && $stable(mir_tgt_q))
    else $error("aggregated port chosen as target");
  a_mir_target: assert property (mir_on_q |-> !mir_rx_q[mir_tgt_q] && !mir_tx_q[mir_tgt_q])
    else $error("mirror target is also a source");
  a_mir_rx: assert property (push && mir_on_q && mir_rx_q[fr_port] && !filt
            |-> w_mir && w_word[PW-1:0] == mir_tgt_q)
    else $error("received frame not mirrored");
  a_mir_keep: assert property (push && !w_drop |-> w_fwd == fwd_raw)
    else $error("mirroring altered forwarding");

endmodule : ffm_filter

`default_nettype wire

// [ffm_port_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// station side taking decisions
// ****************************************
module ffm_port_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic hold,
  input  wire logic slow,
  output logic      dec_ready
);
  logic tog_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end

  // slow mode still drains every other cycle, so the copy port keeps pace
  assign dec_ready = ~hold & (~slow | tog_q);
endmodule : ffm_port_model

`default_nettype wire

// [test_frame_filter_and_port_mirror.sv]
`timescale 1ns/1ps
`default_nettype none

module test_frame_filter_and_port_mirror;
  import ffm_pkg::*;

  typedef struct packed {
    logic       drop;
    ffm_drop_e  why;
    logic [7:0] mask;
    logic       mir;
    logic [2:0] port;
  } ffm_exp_s;

  localparam logic [47:0] MAC_A = 48'h1, MAC_B = 48'h3, MAC_V = 48'h5, MAC_C = 48'h6;
  localparam logic [47:0] MAC_Q = 48'h7, MAC_U = 48'hA, MAC_S = 48'hC, MAC_X = 48'hE;

  logic        sys_clk = 1'h0, sys_rst = 1'h1, fr_valid = 1'h0, fr_is_ip = 1'h0;
  logic        ipf_wr = 1'h0, ipf_en = 1'h0, macf_wr = 1'h0, macf_en = 1'h0;
  logic        macf_discard = 1'h0, mir_apply = 1'h0, mir_en = 1'h0, hold = 1'h0;
  logic        slow = 1'h0, ip_on = 1'h0;
  logic [2:0]  fr_port = '0, macf_port = '0, mir_tgt = '0;
  logic [47:0] fr_src_mac = '0, fr_dst_mac = '0, macf_mac = '0;
  logic [31:0] fr_src_ip = '0, fr_dst_ip = '0, ipf_addr = '0, ip_s = '0, ip_d = '0, rnd;
  logic [11:0] fr_vid = '0;
  logic [4:0]  ipf_idx = '0;
  logic [1:0]  macf_idx = '0;
  logic [7:0]  mir_rx_mask = '0, mir_tx_mask = '0, lag_mask = '0;
  logic [19:0] age_time_s = '0;
  ffm_ippos_e  ipf_pos = IPF_SRC;
  logic        fr_ready, mir_cfg_err, mir_active, dec_valid, dec_ready, dec_drop, dec_mir;
  ffm_drop_e   dec_reason;
  logic [7:0]  dec_fwd_mask;
  logic [2:0]  dec_mir_port;
  int          n_fail = 0, checks_done = 0, k;
  integer      seed = 32'h951C1EC7;
  ffm_exp_s    expq[$];

  // short second so the 300 s floor of aging fits the run
  ffm_filter #(.NPORT(8), .SEC_CYC(8)) i_ffm_filter (.*);
  ffm_port_model i_ffm_port_model (.*);

  initial forever #12.5 sys_clk = ~sys_clk;

  // ****************************************
  // compares and bus cycles
  // ****************************************
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic chk_dec(input ffm_exp_s e);
    ffm_exp_s g;
    g = '{dec_drop, dec_reason, dec_fwd_mask, dec_mir,
          e.mir ? dec_mir_port : e.port};
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: decision %h expected %h", $time, g, e);
    end
  endtask : chk_dec

  function automatic ffm_exp_s ex(input ffm_drop_e w, input logic [7:0] m, input logic r);
    return '{w != DR_NONE, w, m, r, 3'h7};
  endfunction : ex

  // zero ip_s or ip_d means a random address outside every filter entry
  task automatic send(input logic [2:0] p, input logic [47:0] s, input logic [47:0] d,
                      input logic [11:0] v, input ffm_exp_s e);
    rnd = $random(seed);
    fr_valid   <= 1'h1;
    fr_port    <= p;
    fr_src_mac <= s;
    fr_dst_mac <= d;
    fr_vid     <= v;
    fr_is_ip   <= ip_on;
    fr_src_ip  <= (ip_s != 0) ? ip_s : {8'hC0, rnd[23:0]};
    fr_dst_ip  <= (ip_d != 0) ? ip_d : {8'hC1, rnd[23:0]};
    // ready is read once settled, never in the step of the edge that moves it
    @(negedge sys_clk);
    for (k = 0; k < 200 && fr_ready !== 1'h1; k++) @(negedge sys_clk);
    if (k == 200) begin
      n_fail++;
      $display("wrong value at %0t: frame never taken", $time);
      tally_and_finish();
    end
    expq.push_back(e);
    @(posedge sys_clk);
  endtask : send

  task automatic idle(input int n);
    fr_valid <= 1'h0;
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic ipf_put(input logic [4:0] i, input logic [31:0] a, input ffm_ippos_e ps);
    fr_valid <= 1'h0;
    ipf_wr   <= 1'h1;
    ipf_idx  <= i;
    ipf_en   <= 1'h1;
    ipf_addr <= a;
    ipf_pos  <= ps;
    @(posedge sys_clk);
    ipf_wr   <= 1'h0;
    @(posedge sys_clk);
  endtask : ipf_put

  task automatic mac_put(input logic [1:0] i, input logic dis, input logic [47:0] m,
                         input logic [2:0] p);
    fr_valid     <= 1'h0;
    macf_wr      <= 1'h1;
    macf_idx     <= i;
    macf_en      <= 1'h1;
    macf_discard <= dis;
    macf_mac     <= m;
    macf_port    <= p;
    @(posedge sys_clk);
    macf_wr      <= 1'h0;
    @(posedge sys_clk);
  endtask : mac_put

  task automatic mir_set(input logic en, input logic [2:0] t, input logic [7:0] rx,
                         input logic [7:0] tx, input logic [7:0] lag, input logic err,
                         input logic act);
    fr_valid    <= 1'h0;
    mir_apply   <= 1'h1;
    mir_en      <= en;
    mir_tgt     <= t;
    mir_rx_mask <= rx;
    mir_tx_mask <= tx;
    lag_mask    <= lag;
    @(posedge sys_clk);
    mir_apply   <= 1'h0;
    @(negedge sys_clk);
    chk_flag(mir_cfg_err, err);
    chk_flag(mir_active, act);
    @(posedge sys_clk);
  endtask : mir_set

  // a word leaves at the next rising edge when both are high here
  always @(negedge sys_clk) begin
    if (!sys_rst && dec_valid === 1'h1 && dec_ready === 1'h1) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("wrong value at %0t: decision with none expected", $time);
      end else begin
        chk_dec(expq.pop_front());
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(negedge sys_clk);
    chk_flag(fr_ready, 1'h1);
    chk_flag(mir_active, 1'h0);
    @(posedge sys_clk);
    send(3'h1, MAC_A, MAC_U, 12'h1, ex(DR_NONE, 8'hFD, 1'h0));
    send(3'h3, MAC_B, MAC_U, 12'h1, ex(DR_NONE, 8'hF7, 1'h0));
    send(3'h4, MAC_V, MAC_U, 12'h2, ex(DR_NONE, 8'hEF, 1'h0));
    idle(2);
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h0));
    send(3'h1, MAC_A, MAC_V, 12'h1, ex(DR_VLAN, 8'h00, 1'h0));
    send(3'h1, MAC_C, MAC_A, 12'h1, ex(DR_SAME, 8'h00, 1'h0));
    ipf_put(5'h00, 32'h0A000001, IPF_SRC);
    ipf_put(5'h01, 32'h0A000002, IPF_DST);
    ipf_put(5'h1F, 32'h0A000003, IPF_BOTH);
    ip_s = 32'h0A000001;
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h0));
    ip_on = 1'h1;
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_FILTER, 8'h00, 1'h0));
    ip_s = 32'h0;
    ip_d = 32'h0A000001;
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h0));
    ip_d = 32'h0A000002;
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_FILTER, 8'h00, 1'h0));
    ip_d = 32'h0A000003;
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_FILTER, 8'h00, 1'h0));
    ip_d = 32'h0;
    ip_s = 32'h0A000003;
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_FILTER, 8'h00, 1'h0));
    ip_s = 32'h0;
    mac_put(2'h0, 1'h1, MAC_X, 3'h0);
    mac_put(2'h1, 1'h0, MAC_S, 3'h5);
    send(3'h0, MAC_X, MAC_B, 12'h1, ex(DR_FILTER, 8'h00, 1'h0));
    send(3'h1, MAC_A, MAC_X, 12'h1, ex(DR_FILTER, 8'h00, 1'h0));
    send(3'h0, MAC_S, MAC_B, 12'h3, ex(DR_NONE, 8'h20, 1'h0));
    ip_s = 32'h0A000001;
    send(3'h0, MAC_S, MAC_B, 12'h3, ex(DR_FILTER, 8'h00, 1'h0));
    ip_s = 32'h0;
    mir_set(1'h1, 3'h7, 8'h02, 8'h08, 8'h00, 1'h0, 1'h1);
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h1));
    send(3'h3, MAC_B, MAC_A, 12'h1, ex(DR_NONE, 8'h02, 1'h0));
    send(3'h4, MAC_V, MAC_U, 12'h2, ex(DR_NONE, 8'hEF, 1'h1));
    mir_set(1'h1, 3'h1, 8'h02, 8'h08, 8'h00, 1'h1, 1'h1);
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h1));
    mir_set(1'h1, 3'h6, 8'h02, 8'h08, 8'h40, 1'h1, 1'h1);
    mir_set(1'h0, 3'h7, 8'h02, 8'h08, 8'h00, 1'h0, 1'h0);
    send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h0));
    idle(3);
    hold <= 1'h1;
    for (int i = 0; i < 8; i++) send(3'h1, MAC_A, MAC_B, 12'h1, ex(DR_NONE, 8'h08, 1'h0));
    fr_valid <= 1'h0;
    @(negedge sys_clk);
    chk_flag(fr_ready, 1'h0);
    chk_flag(dec_valid, 1'h1);
    @(posedge sys_clk);
    hold <= 1'h0;
    slow <= 1'h1;
    for (int i = 0; i < 10; i++) send(3'h3, MAC_B, MAC_A, 12'h1, ex(DR_NONE, 8'h02, 1'h0));
    idle(5000);
    send(3'h2, MAC_Q, MAC_A, 12'h1, ex(DR_NONE, 8'hFB, 1'h0));
    send(3'h0, MAC_S, MAC_B, 12'h1, ex(DR_NONE, 8'h20, 1'h0));
    idle(1);
    for (k = 0; k < 300 && expq.size() != 0; k++) @(posedge sys_clk);
    if (expq.size() != 0) begin
      n_fail++;
      $display("wrong value at %0t: decisions missing", $time);
    end
    tally_and_finish();
  end
endmodule : test_frame_filter_and_port_mirror

`default_nettype wire
